/* File: supply_object_dictionary_bank.sv */
// Object dictionary register bank of a programmable DC supply.
//
// Notes on behaviour
// - Operation status is live, read-only at 0x200d.
// - Reading status never clears any bit.
// - Operation status returned as one 32-bit word.
// - Questionable status read-only, fixed subset layout.
// - Bit 0 standby, bit 1 output active.
// - Trip bits: current 4, volt 5, power 6, undervolt 8.
// - Bit 7 flags sense voltage out of bounds.
// - Bit 12 start failed, bit 13 start pending.
// - Bits 16, 17 flag terminal rating exceeded.
// - Bits 10, 11 flag linear/resistor power excess.
// - Bit 29 flags regulation lost.
// - Bit 30 flags internal firmware update.
// - Bit 19 aux fuse open, bit 27 resistor hot.
// - Measurements read-only at 0x2101 to 0x2103.
// - Targets written at one index, read at next.
// - Four trip levels, odd write, next read.
// - Rise slews stored, applied in matching regulation.
// - Fall slews stored, written then read next.
// - Restore write reloads factory defaults, not readable.
// - Guard blocks configuration changes, read below write.
// - Sense location setting, separate write/read indices.
// - Regulation select and target origin settings.
`timescale 1ns/100ps
`default_nettype none
module supply_object_dictionary_bank
   import supply_od_pkg::*;
#(
   parameter int WORD_W = 32
) (
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst,
   // Object access from the network side
   input  wire supply_od_pkg::od_req_t    req,
   output var  supply_od_pkg::od_ans_t    ans_q,
   // Plant conditions and measurements
   input  wire supply_od_pkg::cond_t      cond,
   input  wire supply_od_pkg::reg_state_t reg_state,
   input  wire supply_od_pkg::od_word_t   measured_current,
   input  wire supply_od_pkg::od_word_t   measured_voltage,
   input  wire supply_od_pkg::od_word_t   measured_power,
   // Settings toward the regulator
   output var  supply_od_pkg::settings_t  setting_q,
   output logic                           output_enable_q,
   output supply_od_pkg::od_word_t        active_rise_slew_q,
   output supply_od_pkg::od_word_t        active_fall_slew_q,
   output logic                           factory_reload_q
);
   import supply_od_pkg::*;

   if (WORD_W != DATA_W) begin : g_width_check
      $error("Object words must be 32 bits wide.");
   end

   od_word_t                status_q;
   od_word_t                status_d;
   od_word_t                quest_q;
   od_word_t                quest_d;
   logic [NUM_SETTINGS-1:0] hit_wr;
   logic [NUM_SETTINGS-1:0] hit_rd;
   logic                    locked;
   logic                    single_op;
   logic                    reload_hit;
   logic                    reload_ok;
   logic                    write_ok;
   logic                    read_ok;
   od_word_t                read_data;

   // Status words are rebuilt from the live conditions every cycle, never latched.
   always_comb begin
      status_d                 = '0;
      status_d[ST_STANDBY]     = ~setting_q[SLOT_OUTPUT][0];
      status_d[ST_LIVE]        = setting_q[SLOT_OUTPUT][0];
      status_d[ST_CUR_TRIP]    = cond.current_trip_flag;
      status_d[ST_VHI_TRIP]    = cond.voltage_high_trip_flag;
      status_d[ST_PWR_TRIP]    = cond.power_trip_flag;
      status_d[ST_VLO_TRIP]    = cond.voltage_low_trip_flag;
      status_d[ST_SENSE]       = cond.sense_lead_fault;
      status_d[ST_SHUTDOWN]    = cond.shutdown;
      status_d[ST_LIN_PWR]     = cond.linear_stage_power_limit;
      status_d[ST_RES_PWR]     = cond.resistor_power_limit;
      status_d[ST_START_FAIL]  = cond.target_start_failed;
      status_d[ST_START_WAIT]  = cond.target_start_pending;
      status_d[ST_PHASE]       = cond.phase_current_high;
      status_d[ST_LINK]        = cond.link_corrupt;
      status_d[ST_CUR_RATING]  = cond.current_rating_exceeded;
      status_d[ST_VOLT_RATING] = cond.voltage_rating_exceeded;
      status_d[ST_LIN_HOT]     = cond.linear_module_hot;
      status_d[ST_FUSE]        = cond.aux_fuse_open;
      status_d[ST_INTERLOCK]   = cond.interlock_open;
      status_d[ST_MAINT]       = cond.maintenance;
      status_d[ST_DIODE_HOT]   = cond.diode_module_hot;
      status_d[ST_CONFIG]      = cond.config_incompatible;
      status_d[ST_STACK]       = cond.stack_exceeded;
      status_d[ST_LINE]        = cond.line_fault;
      status_d[ST_RES_HOT]     = cond.resistor_module_hot;
      status_d[ST_BELOW_MIN]   = cond.below_rated_voltage;
      status_d[ST_REG_LOST]    = cond.regulation_lost;
      status_d[ST_UPDATE]      = cond.target_firmware_update;
   end

   // The questionable word repacks status conditions plus overtemp_protect, input_power_lost and the regulation state.
   always_comb begin
      quest_d               = '0;
      quest_d[QS_VOLT_PROT] = cond.voltage_rating_exceeded;
      quest_d[QS_CUR_TRIP]  = cond.current_trip_flag;
      quest_d[QS_VHI_TRIP]  = cond.voltage_high_trip_flag;
      quest_d[QS_PWR_TRIP]  = cond.power_trip_flag;
      quest_d[QS_CUR_PROT]  = cond.current_rating_exceeded;
      quest_d[QS_TEMP]      = cond.overtemp_protect;
      quest_d[QS_SENSE]     = cond.sense_lead_fault;
      quest_d[QS_CC]        = (reg_state == REG_CURRENT);
      quest_d[QS_CV]        = (reg_state == REG_VOLTAGE);
      quest_d[QS_CR]        = (reg_state == REG_RESISTANCE);
      quest_d[QS_CP]        = (reg_state == REG_POWER);
      quest_d[QS_SOFT]      = cond.current_trip_flag | cond.voltage_high_trip_flag
                            | cond.power_trip_flag;
      quest_d[QS_HARD]      = cond.voltage_rating_exceeded | cond.current_rating_exceeded
                            | cond.overtemp_protect | cond.sense_lead_fault;
      quest_d[QS_ILOC]      = cond.interlock_open;
      quest_d[QS_IPL]       = cond.input_power_lost;
      quest_d[QS_ADIF]      = cond.line_fault;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         status_q <= '0;
         quest_q  <= '0;
      end else begin
         status_q <= status_d;
         quest_q  <= quest_d;
      end
   end

   // Index decode of the settings table, one slot per setting object with a write and a read index.
   for (genvar i = 0; i < NUM_SETTINGS; i++) begin : g_slot
      assign hit_wr[i] = (req.index == SETTING_WR_INDEX[i]);
      assign hit_rd[i] = (req.index == SETTING_RD_INDEX[i]);

      always_ff @(posedge clock) begin
         if (rst || reload_ok) begin
            setting_q[i] <= SETTING_RESET[i];
         end else if (write_ok && hit_wr[i]) begin
            setting_q[i] <= req.data;
         end
      end
   end

   // The guard stops configuration and target writes, but the guard itself and the output
   // object stay writable so a locked unit can still be switched off or unlocked.
   assign locked     = setting_q[SLOT_GUARD][0];
   assign single_op  = req.wr ^ req.rd;
   assign reload_hit = (req.index == IDX_FACTORY_RELOAD);
   assign reload_ok  = req.wr && single_op && reload_hit && !locked;
   assign write_ok   = req.wr && single_op && (|hit_wr)
                     && (!locked || hit_wr[SLOT_GUARD] || hit_wr[SLOT_OUTPUT]);

   // Reads have no side effects; only the answer register changes.
   always_comb begin
      read_ok   = req.rd && single_op;
      read_data = '0;
      case (req.index)
         IDX_OPERATION_STATUS:    read_data = status_q;
         IDX_QUESTIONABLE_STATUS: read_data = quest_q;
         IDX_MEASURED_CURRENT:    read_data = measured_current;
         IDX_MEASURED_VOLTAGE:    read_data = measured_voltage;
         IDX_MEASURED_POWER:      read_data = measured_power;
         default: begin
            for (int k = 0; k < NUM_SETTINGS; k++) begin
               if (hit_rd[k]) begin
                  read_data = setting_q[k];
               end
            end
            read_ok = read_ok && (|hit_rd);
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         ans_q <= '0;
      end else begin
         ans_q.done  <= req.wr | req.rd;
         ans_q.abort <= (req.wr | req.rd) && !(read_ok || write_ok || reload_ok);
         ans_q.data  <= read_ok ? read_data : '0;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         factory_reload_q <= 1'b0;
      end else begin
         factory_reload_q <= reload_ok;
      end
   end

   always_ff @(posedge clock) begin
      if (rst || reload_ok) begin
         output_enable_q <= 1'b0;
      end else if (write_ok && hit_wr[SLOT_OUTPUT]) begin
         output_enable_q <= req.data[0];
      end
   end

   // Only the slew of the present regulation state is handed on; others read as zero.
   always_ff @(posedge clock) begin
      if (rst) begin
         active_rise_slew_q <= '0;
         active_fall_slew_q <= '0;
      end else begin
         case (reg_state)
            REG_CURRENT: begin
               active_rise_slew_q <= setting_q[SLOT_CURRENT_RISE];
               active_fall_slew_q <= setting_q[SLOT_CURRENT_FALL];
            end
            REG_VOLTAGE: begin
               active_rise_slew_q <= setting_q[SLOT_VOLTAGE_RISE];
               active_fall_slew_q <= setting_q[SLOT_VOLTAGE_FALL];
            end
            REG_POWER: begin
               active_rise_slew_q <= setting_q[SLOT_POWER_RISE];
               active_fall_slew_q <= setting_q[SLOT_POWER_FALL];
            end
            default: begin
               active_rise_slew_q <= '0;
               active_fall_slew_q <= '0;
            end
         endcase
      end
   end

endmodule // supply_object_dictionary_bank
`default_nettype wire

/* File: supply_od_pkg.sv */
// Shared indices, field positions, carriers and defaults of the supply object dictionary.
`default_nettype none
package supply_od_pkg;

   localparam int DATA_W       = 32;
   localparam int INDEX_W      = 16;
   localparam int NUM_SETTINGS = 18;

   typedef logic [INDEX_W-1:0] od_index_t;
   typedef logic [DATA_W-1:0]  od_word_t;

   // Read-only and write-only objects outside the settings table.
   localparam od_index_t IDX_QUESTIONABLE_STATUS = 16'h200b;
   localparam od_index_t IDX_OPERATION_STATUS    = 16'h200d;
   localparam od_index_t IDX_MEASURED_CURRENT    = 16'h2101;
   localparam od_index_t IDX_MEASURED_VOLTAGE    = 16'h2102;
   localparam od_index_t IDX_MEASURED_POWER      = 16'h2103;
   localparam od_index_t IDX_FACTORY_RELOAD      = 16'h2701;

   // Slots of the settings table.
   localparam int SLOT_OUTPUT          = 0;
   localparam int SLOT_CURRENT_TARGET  = 1;
   localparam int SLOT_VOLTAGE_TARGET  = 2;
   localparam int SLOT_POWER_TARGET    = 3;
   localparam int SLOT_CURRENT_TRIP    = 4;
   localparam int SLOT_VOLTAGE_HI_TRIP = 5;
   localparam int SLOT_POWER_TRIP      = 6;
   localparam int SLOT_VOLTAGE_LO_TRIP = 7;
   localparam int SLOT_CURRENT_RISE    = 8;
   localparam int SLOT_VOLTAGE_RISE    = 9;
   localparam int SLOT_POWER_RISE      = 10;
   localparam int SLOT_CURRENT_FALL    = 11;
   localparam int SLOT_VOLTAGE_FALL    = 12;
   localparam int SLOT_POWER_FALL      = 13;
   localparam int SLOT_REGULATION      = 14;
   localparam int SLOT_GUARD           = 15;
   localparam int SLOT_SENSE           = 16;
   localparam int SLOT_ORIGIN          = 17;

   localparam od_index_t SETTING_WR_INDEX [NUM_SETTINGS] = '{
      16'h200f, 16'h2201, 16'h2203, 16'h2205, 16'h2301, 16'h2303, 16'h2305, 16'h2307, 16'h2401,
      16'h2403, 16'h2405, 16'h2409, 16'h240b, 16'h240d, 16'h2503, 16'h2703, 16'h2706, 16'h270a};
   localparam od_index_t SETTING_RD_INDEX [NUM_SETTINGS] = '{
      16'h2010, 16'h2202, 16'h2204, 16'h2206, 16'h2302, 16'h2304, 16'h2306, 16'h2308, 16'h2402,
      16'h2404, 16'h2406, 16'h240a, 16'h240c, 16'h240e, 16'h2504, 16'h2702, 16'h2707, 16'h270b};
   // Values after reset and after a factory reload.
   localparam od_word_t SETTING_RESET [NUM_SETTINGS] = '{default: 32'h0000_0000};

   // Bit positions in the operation status word.
   localparam int ST_STANDBY = 0,  ST_LIVE = 1,  ST_CUR_TRIP = 4,  ST_VHI_TRIP = 5;
   localparam int ST_PWR_TRIP = 6, ST_SENSE = 7, ST_VLO_TRIP = 8,  ST_SHUTDOWN = 9;
   localparam int ST_LIN_PWR = 10, ST_RES_PWR = 11, ST_START_FAIL = 12, ST_START_WAIT = 13;
   localparam int ST_PHASE = 14,   ST_LINK = 15, ST_CUR_RATING = 16, ST_VOLT_RATING = 17;
   localparam int ST_LIN_HOT = 18, ST_FUSE = 19, ST_INTERLOCK = 20, ST_MAINT = 22;
   localparam int ST_DIODE_HOT = 23, ST_CONFIG = 24, ST_STACK = 25, ST_LINE = 26;
   localparam int ST_RES_HOT = 27, ST_BELOW_MIN = 28, ST_REG_LOST = 29, ST_UPDATE = 30;

   // Bit positions in the questionable status word.
   localparam int QS_VOLT_PROT = 0, QS_CUR_TRIP = 1, QS_VHI_TRIP = 2, QS_PWR_TRIP = 3;
   localparam int QS_CUR_PROT = 4, QS_TEMP = 5, QS_SENSE = 6, QS_CC = 7, QS_CV = 8, QS_CR = 9;
   localparam int QS_CP = 10, QS_SOFT = 11, QS_HARD = 12, QS_ILOC = 13, QS_IPL = 14, QS_ADIF = 15;

   typedef enum logic [2:0] {
      REG_NONE, REG_CURRENT, REG_VOLTAGE, REG_RESISTANCE, REG_POWER
   } reg_state_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      od_index_t  index;
      od_word_t   data;
   } od_req_t;

   typedef struct packed {
      logic       done;
      logic       abort;
      od_word_t   data;
   } od_ans_t;

   typedef struct packed {
      logic current_trip_flag, voltage_high_trip_flag, power_trip_flag, voltage_low_trip_flag;
      logic sense_lead_fault, shutdown, linear_stage_power_limit, resistor_power_limit;
      logic target_start_failed, target_start_pending, phase_current_high, link_corrupt;
      logic current_rating_exceeded, voltage_rating_exceeded, linear_module_hot, aux_fuse_open;
      logic interlock_open, maintenance, diode_module_hot, config_incompatible;
      logic stack_exceeded, line_fault, resistor_module_hot, below_rated_voltage;
      logic regulation_lost, target_firmware_update, overtemp_protect, input_power_lost;
   } cond_t;

   typedef od_word_t [NUM_SETTINGS-1:0] settings_t;

endpackage
`default_nettype wire

/* File: supply_od_asserts.sv */
// Port checker of the supply object dictionary bank.
`timescale 1ns/100ps
`default_nettype none
module supply_od_asserts
   import supply_od_pkg::*;
#(
   parameter int WORD_W = 32
) (
   // Clock and reset
   input wire logic                      clock,
   input wire logic                      rst,
   // Object port
   input wire supply_od_pkg::od_req_t    req,
   input wire supply_od_pkg::od_ans_t    ans_q,
   // Regulator side
   input wire supply_od_pkg::reg_state_t reg_state,
   input wire supply_od_pkg::settings_t  setting_q,
   input wire logic                      output_enable_q,
   input wire supply_od_pkg::od_word_t   active_rise_slew_q,
   input wire supply_od_pkg::od_word_t   active_fall_slew_q,
   input wire logic                      factory_reload_q
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic w1, r1, d0, locked;
   assign w1 = req.wr && !req.rd;
   assign r1 = req.rd && !req.wr;
   assign d0 = req.data[0];
   assign locked = setting_q[SLOT_GUARD][0];
   property p_answer; req.wr || req.rd |=> ans_q.done; endproperty
   a_answer: assert property (p_answer) else $error("request left unanswered");
   property p_clash; req.wr && req.rd |=> ans_q.abort && $stable(setting_q); endproperty
   a_clash: assert property (p_clash) else $error("mixed request accepted");
   property p_ro_wr;
      w1 && (req.index == IDX_OPERATION_STATUS || req.index == IDX_QUESTIONABLE_STATUS)
      |=> ans_q.abort && $stable(setting_q);
   endproperty
   a_ro_wr: assert property (p_ro_wr) else $error("status write accepted");
   property p_meas_wr; w1 && req.index inside {[16'h2101:16'h2103]} |=> ans_q.abort; endproperty
   a_meas_wr: assert property (p_meas_wr) else $error("measurement write accepted");
   property p_reload_rd; r1 && req.index == IDX_FACTORY_RELOAD |=> ans_q.abort; endproperty
   a_reload_rd: assert property (p_reload_rd) else $error("restore object readable");
   property p_reload;
      w1 && req.index == IDX_FACTORY_RELOAD && !locked |=> setting_q == '0 ##[0:1] factory_reload_q;
   endproperty
   a_reload: assert property (p_reload) else $error("restore not carried out");
   property p_guard;
      w1 && req.index == 16'h2201 && locked |=> ans_q.abort && $stable(setting_q);
   endproperty
   a_guard: assert property (p_guard) else $error("locked target changed");
   property p_out; w1 && req.index == 16'h200f |=> output_enable_q == $past(d0); endproperty
   a_out: assert property (p_out) else $error("output state not taken");
   property p_abort_data; ans_q.abort |-> ans_q.done && ans_q.data == '0; endproperty
   a_abort_data: assert property (p_abort_data) else $error("refusal carries data");
   property p_res_slew;
      (reg_state == REG_RESISTANCE) [*2] |=> active_rise_slew_q == '0 && active_fall_slew_q == '0;
   endproperty
   a_res_slew: assert property (p_res_slew) else $error("slew used outside its state");
endmodule // supply_od_asserts
bind supply_object_dictionary_bank supply_od_asserts #(.WORD_W(WORD_W)) i_supply_od_asserts (
   .clock(clock), .rst(rst), .req(req), .ans_q(ans_q), .reg_state(reg_state),
   .setting_q(setting_q), .output_enable_q(output_enable_q),
   .active_rise_slew_q(active_rise_slew_q), .active_fall_slew_q(active_fall_slew_q),
   .factory_reload_q(factory_reload_q));
`default_nettype wire

/* File: od_host_model.sv */
// Network master model issuing object reads and writes.
`timescale 1ns/100ps
`default_nettype none
module od_host_model
   import supply_od_pkg::*;
(
   // Clock
   input  wire logic                   clock,
   // Object port
   output var  supply_od_pkg::od_req_t req,
   input  wire supply_od_pkg::od_ans_t ans_q
);
   initial req = '0;
   // Released lines show inverted values so a stale index or word is never mistaken for live.
   task automatic xfer(input logic w, input logic r, input od_index_t idx, input od_word_t dat,
                       output od_ans_t a);
      @(negedge clock);
      req <= '{wr: w, rd: r, index: idx, data: dat};
      // The answer stands for one cycle only, so it is taken at the next falling edge.
      @(negedge clock);
      a = ans_q;
      req <= '{wr: 1'b0, rd: 1'b0, index: ~idx, data: ~dat};
   endtask
endmodule // od_host_model
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench of the supply object dictionary bank.
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import supply_od_pkg::*;
   logic       clock, rst, oen, reload;
   od_req_t    req;
   od_ans_t    ans_q, a;
   cond_t      cond;
   reg_state_t reg_state;
   od_word_t   mcur, mvol, mpwr, rise, fall, d;
   settings_t  setting_q;
   int         n_mismatch = 0, compares = 0, cycles = 0, reloads = 0;
   // Status bit raised by each condition input above position 1, by its position in the packed vector.
   int smap [28] = '{0, 0, 30, 29, 28, 27, 26, 25, 24, 23, 22, 20, 19, 18, 17, 16, 15, 14,
                     13, 12, 11, 10, 9, 7, 8, 6, 5, 4};
   supply_object_dictionary_bank #(.WORD_W(32)) i_supply_object_dictionary_bank (
      .clock(clock), .rst(rst), .req(req), .ans_q(ans_q), .cond(cond), .reg_state(reg_state),
      .measured_current(mcur), .measured_voltage(mvol), .measured_power(mpwr),
      .setting_q(setting_q), .output_enable_q(oen), .active_rise_slew_q(rise),
      .active_fall_slew_q(fall), .factory_reload_q(reload));
   od_host_model i_od_host_model (.clock(clock), .req(req), .ans_q(ans_q));
   task automatic chk(input string what, input od_word_t seen, input od_word_t exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   function automatic od_word_t v(input int i);
      return 32'h5a00_0000 | 32'(i << 4);
   endfunction
   task automatic rd(input od_index_t i);
      i_od_host_model.xfer(1'b0, 1'b1, i, 32'h0, a);
      d = a.data;
   endtask
   task automatic wr(input od_index_t i, input od_word_t dat);
      i_od_host_model.xfer(1'b1, 1'b0, i, dat, a);
   endtask
   task automatic t_settings;
      for (int i = 0; i < NUM_SETTINGS; i++) begin
         wr(SETTING_WR_INDEX[i], v(i));
         chk("write ack", {30'h0, a.done, a.abort}, 32'h2);
         rd(SETTING_RD_INDEX[i]);
         chk("readback", d, v(i));
         chk("setting", setting_q[i], v(i));
      end
   endtask
   task automatic t_slew;
      reg_state_t st [3] = '{REG_CURRENT, REG_VOLTAGE, REG_POWER};
      for (int k = 0; k < 3; k++) begin
         reg_state = st[k];
         repeat (3) @(negedge clock);
         chk("rise slew", rise, v(SLOT_CURRENT_RISE + k));
         chk("fall slew", fall, v(SLOT_CURRENT_FALL + k));
      end
      reg_state = REG_RESISTANCE;
      repeat (3) @(negedge clock);
      chk("idle slew", rise | fall, 32'h0);
   endtask
   task automatic t_status;
      od_word_t e;
      for (int p = 2; p < 28; p++) begin
         cond = cond_t'(28'h1 << p);
         e = (32'h1 << smap[p]) | 32'h1;
         repeat (2) @(negedge clock);
         rd(IDX_OPERATION_STATUS);
         chk("status", d, e);
         rd(IDX_OPERATION_STATUS);
         chk("status again", d, e);
      end
      cond = '0;
      cond.current_trip_flag = 1'b1;
      cond.voltage_rating_exceeded = 1'b1;
      reg_state = REG_VOLTAGE;
      repeat (2) @(negedge clock);
      rd(IDX_QUESTIONABLE_STATUS);
      chk("questionable", d, 32'h0000_1903);
      // Power regulation with the hard faults except voltage rating, and the remaining soft trips.
      cond = cond_t'(28'h680_8843);
      reg_state = REG_POWER;
      repeat (2) @(negedge clock);
      rd(IDX_QUESTIONABLE_STATUS);
      chk("questionable", d, 32'h0000_fc7c);
      cond = '0;
      for (int k = 0; k < 2; k++) begin
         reg_state = (k == 0) ? REG_CURRENT : REG_RESISTANCE;
         repeat (2) @(negedge clock);
         rd(IDX_QUESTIONABLE_STATUS);
         chk("regulation bits", d, (k == 0) ? 32'h0000_0080 : 32'h0000_0200);
      end
   endtask
   task automatic t_output;
      wr(16'h200f, 32'h1);
      rd(16'h2010);
      chk("output read", d, 32'h1);
      chk("output enable", 32'(oen), 32'h1);
      rd(IDX_OPERATION_STATUS);
      chk("live status", d, 32'h2);
      wr(16'h200f, 32'h0);
   endtask
   task automatic t_refuse;
      od_index_t bad [10] = '{16'h200b, 16'h200d, 16'h2101, 16'h2103, 16'h3000, 16'h200f,
                              16'h2201, 16'h2701, 16'h2409, 16'h3000};
      for (int k = 0; k < 11; k++) begin
         i_od_host_model.xfer(k < 5 || k == 10, k >= 5, bad[k % 10], 32'h0bad_0bad, a);
         chk("refused", 32'(a.abort), 32'h1);
         chk("refused data", a.data, 32'h0);
      end
      rd(16'h2202);
      chk("target kept", d, v(1));
      mcur = 32'h3fc0_0000;
      mvol = 32'h4120_0000;
      mpwr = 32'h4348_0000;
      rd(16'h2101);
      chk("current", d, 32'h3fc0_0000);
      rd(16'h2102);
      chk("voltage", d, 32'h4120_0000);
      rd(16'h2103);
      chk("power", d, 32'h4348_0000);
   endtask
   task automatic t_guard;
      wr(16'h2703, 32'h1);
      rd(16'h2702);
      chk("guard read", d, 32'h1);
      wr(16'h2201, 32'h1111_1111);
      chk("locked target", 32'(a.abort), 32'h1);
      wr(16'h2701, 32'h0);
      chk("locked restore", 32'(a.abort), 32'h1);
      wr(16'h200f, 32'h1);
      chk("locked output", 32'(a.abort), 32'h0);
      wr(16'h2703, 32'h0);
      wr(16'h2701, 32'h0);
      repeat (2) @(negedge clock);
      chk("reload pulses", 32'(reloads), 32'h1);
      chk("defaults", setting_q[SLOT_CURRENT_TARGET] | setting_q[SLOT_OUTPUT], 32'h0);
      chk("output off", 32'(oen), 32'h0);
      rd(16'h2202);
      chk("target after reload", d, 32'h0);
   endtask
   always @(negedge clock) if (reload === 1'b1) reloads++;
   // The whole sequence needs well under a thousand cycles, so a hang shows quickly.
   always @(posedge clock) begin
      cycles++;
      if (cycles == 4000) begin
         n_mismatch++;
         end_sim();
      end
   end
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      cond = '0;
      reg_state = REG_NONE;
      mcur = 32'h0;
      mvol = 32'h0;
      mpwr = 32'h0;
      repeat (20) @(negedge clock);
      rst = 1'b0;
      t_settings();
      t_slew();
      t_status();
      t_output();
      t_refuse();
      t_guard();
      end_sim();
   end
endmodule // testbench
`default_nettype wire
